/* vrc_ctrl.sv */
// Control and indicator logic of the serial video reclocker
//
// Notes on behaviour
// - Clock select high: second output carries clock.
// - Clock edge within 10% of bit centre.
// - Clock select defaults low: second output data.
// - Silence low mutes all serial outputs.
// - Bypass in clock mode mutes second output.
// - Unsupported rate in clock mode: output invalid.
// - Rate code 00 auto, 01 SD, 10 HD.
// - Rate select defaults to automatic detection.
// - Lock high only with data and loop lock.
// - Forced bypass holds lock indicator low.
// - Bypass high passes data without retiming.
// - Bypass low: auto bypass when unlocked/unsupported.
// - Silencing wins over bypass.
// - Silence input defaults to outputs enabled.
// - Bypass input defaults to automatic bypass.
// - Unlocked and not silenced: retiming bypassed.
// - Standard flag high only at 270 Mbps.
// - Standard flag registered, low while unlocked.
// - Standard flag valid one reference period later.
// - Lock drops within 1 ms of change.
// - Lock asserts within 15 ms of data.
// - Muted pairs drive fixed opposite levels.
// - Refused rates never lock, force bypass.
`default_nettype none
module vrc_ctrl #(
    parameter int LOCK_SETTLE_CYC = 16      // Qualified cycles before lock
) (
    input  wire logic             clk_i,    // Reference-derived block clock
    input  wire logic             rst_i,    // Synchronous reset, active high
    // Pins
    input  wire vrc_pkg::vrc_pins_t   pins_i,    // Control inputs
    input  wire vrc_pkg::vrc_cdr_t    cdr_i,     // Recovery loop status
    input  wire vrc_pkg::vrc_serial_t serial_i,  // Serial data and clock
    output logic                  lock_indicator_o,
    output logic                  standard_rate_flag_o,
    output logic                  second_output_valid_o,
    output vrc_pkg::vrc_diff_t    primary_serial_output_o,
    output vrc_pkg::vrc_diff_t    second_serial_output_o,
    // Wishbone slave
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    input  wire logic             we_i,
    input  wire logic [3:0]       adr_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic [31:0]      dat_i,
    output logic [31:0]           dat_o,
    output logic                  ack_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    vrc_pkg::vrc_state_t st_r;              // Registered state
    vrc_pkg::vrc_state_t st_nxt;            // Next state

    // Reset value of the pin synchronisers: the pulled levels, so that an
    // undriven pin reads its default from the first cycle.
    localparam vrc_pkg::vrc_pins_t PIN_DEFAULT = '{
        clk_sel:   1'b0,                    // Pulled down
        rate_sel:  vrc_pkg::RATE_AUTO,      // Pulled down
        bypass:    1'b0,                    // Pulled down
        silence_n: 1'b1                     // Pulled up
    };

    // Muted pair level
    localparam vrc_pkg::vrc_diff_t DIFF_MUTE = '{p: 1'b0, n: 1'b1};

    // Combinational helpers
    logic        rate_ok;                   // Detected rate fits the mode
    logic        qualified;                 // All lock conditions hold
    logic        force_byp;                 // Pin or software bypass
    logic        muted;                     // Any silencing source
    logic        bus_req;                   // Bus cycle awaiting ack
    logic [31:0] status_word;               // Status register image

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;

        // Two flops on every pin, loop status and serial input; stage one feeds stage two only
        st_nxt.pin_s1 = pins_i;
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.cdr_s1 = cdr_i;
        st_nxt.cdr_s2 = st_r.cdr_s1;
        // Serial paths share the pipe depth so clock and data stay aligned
        st_nxt.ser_s1 = serial_i;
        st_nxt.ser_s2 = st_r.ser_s1;

        // Mode decode; code 11 is a test mode, treated here as automatic
        case (st_r.pin_s2.rate_sel)
            vrc_pkg::RATE_AUTO:
                rate_ok = (st_r.cdr_s2.rate == vrc_pkg::DET_SD)
                       || (st_r.cdr_s2.rate == vrc_pkg::DET_HD);
            vrc_pkg::RATE_SD:
                rate_ok = (st_r.cdr_s2.rate == vrc_pkg::DET_SD);
            vrc_pkg::RATE_HD:
                rate_ok = (st_r.cdr_s2.rate == vrc_pkg::DET_HD);
            default:
                rate_ok = (st_r.cdr_s2.rate == vrc_pkg::DET_SD)
                       || (st_r.cdr_s2.rate == vrc_pkg::DET_HD);
        endcase

        // Forced bypass from pin or software
        force_byp = st_r.pin_s2.bypass || st_r.ctrl_r[vrc_pkg::CTRL_BYPASS_BIT];

        // Refused rates never satisfy rate_ok, so they never lock
        qualified = st_r.cdr_s2.loop_locked && st_r.cdr_s2.data_present
                 && rate_ok && !force_byp;

        // Settle filter: counts qualified cycles, any miss restarts it
        if (!qualified)
        begin
            st_nxt.settle_r = '0;
        end
        else if (st_r.settle_r < 21'(LOCK_SETTLE_CYC))
        begin
            st_nxt.settle_r = st_r.settle_r + 21'h1;
        end

        // Lock drops the cycle after a miss, far inside the drop limit
        st_nxt.lock_r = qualified
                     && (st_r.settle_r >= 21'(LOCK_SETTLE_CYC));

        // Standard flag follows lock by one cycle, low while unlocked
        st_nxt.std_r = st_r.lock_r
                    && (st_r.cdr_s2.rate == vrc_pkg::DET_SD);

        // Bypass when forced or whenever unlocked
        st_nxt.bypass_r = force_byp || !st_r.lock_r;

        // Silencing sources; they override bypass
        muted = !st_r.pin_s2.silence_n
             || st_r.ctrl_r[vrc_pkg::CTRL_MUTE_BIT];
        st_nxt.mute_r = muted;

        // Clock mode content is meaningless while bypassing
        st_nxt.valid2_r = !(st_r.pin_s2.clk_sel && st_r.bypass_r);

        // Primary output: mute, else raw or retimed data
        if (muted)
        begin
            st_nxt.out1_r = DIFF_MUTE;
        end
        else if (st_r.bypass_r)
        begin
            st_nxt.out1_r = '{p: st_r.ser_s2.raw, n: !st_r.ser_s2.raw};
        end
        else
        begin
            st_nxt.out1_r = '{p: st_r.ser_s2.retimed, n: !st_r.ser_s2.retimed};
        end

        // Second output: clock or second data copy
        if (muted)
        begin
            st_nxt.out2_r = DIFF_MUTE;
        end
        else if (st_r.pin_s2.clk_sel)
        begin
            if (st_r.bypass_r)
            begin
                st_nxt.out2_r = DIFF_MUTE;
            end
            else
            begin
                st_nxt.out2_r = '{p: st_r.ser_s2.rec_clk,
                                  n: !st_r.ser_s2.rec_clk};
            end
        end
        else if (st_r.bypass_r)
        begin
            st_nxt.out2_r = '{p: st_r.ser_s2.raw, n: !st_r.ser_s2.raw};
        end
        else
        begin
            st_nxt.out2_r = '{p: st_r.ser_s2.retimed, n: !st_r.ser_s2.retimed};
        end

        // Status image
        status_word = '0;
        status_word[vrc_pkg::ST_LOCK_BIT]   = st_r.lock_r;
        status_word[vrc_pkg::ST_STD_BIT]    = st_r.std_r;
        status_word[vrc_pkg::ST_BYPASS_BIT] = st_r.bypass_r;
        status_word[vrc_pkg::ST_MUTE_BIT]   = st_r.mute_r;
        status_word[vrc_pkg::ST_CLKSEL_BIT] = st_r.pin_s2.clk_sel;
        status_word[vrc_pkg::ST_VALID_BIT]  = st_r.valid2_r;
        status_word[vrc_pkg::ST_MODE_LSB +: 2] = st_r.pin_s2.rate_sel;

        // Bus: ack one cycle after the request, dropped after one cycle
        bus_req      = cyc_i && stb_i && !st_r.ack_r;
        st_nxt.ack_r = bus_req;
        if (bus_req)
        begin
            // Read data captured with the ack; unmapped words read zero
            case (adr_i)
                vrc_pkg::CTRL_OFS:   st_nxt.dat_r = {30'h0, st_r.ctrl_r};
                vrc_pkg::STATUS_OFS: st_nxt.dat_r = status_word;
                default:             st_nxt.dat_r = 32'h0;
            endcase
        end
        // Write lands on the edge where the master sees ack
        if (cyc_i && stb_i && st_r.ack_r && we_i && sel_i[0]
            && (adr_i == vrc_pkg::CTRL_OFS))
        begin
            st_nxt.ctrl_r = dat_i[1:0];
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r          <= '0;
            st_r.pin_s1   <= PIN_DEFAULT;
            st_r.pin_s2   <= PIN_DEFAULT;
            st_r.ctrl_r   <= vrc_pkg::CTRL_RST;
            st_r.bypass_r <= 1'b1;
            st_r.valid2_r <= 1'b1;
            st_r.out1_r   <= DIFF_MUTE;
            st_r.out2_r   <= DIFF_MUTE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign lock_indicator_o        = st_r.lock_r;
    assign standard_rate_flag_o    = st_r.std_r;
    assign second_output_valid_o   = st_r.valid2_r;
    assign primary_serial_output_o = st_r.out1_r;
    assign second_serial_output_o  = st_r.out2_r;
    assign dat_o                   = st_r.dat_r;
    assign ack_o                   = st_r.ack_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    localparam int STD_LAT = vrc_pkg::STD_VALID_CYC;
    // Longest wait from a qualified start to lock, one spare cycle
    localparam int ACQ_LAT = LOCK_SETTLE_CYC + 2;

    sequence s_bypass_pin;
        st_r.pin_s2.bypass;
    endsequence

    sequence s_silenced;
        !st_r.pin_s2.silence_n ##1 1'b1;
    endsequence

    // Live path with retiming in use
    sequence s_retiming;
        !muted && !st_r.bypass_r;
    endsequence

    // Live path with retiming bypassed
    sequence s_passing_raw;
        !muted && st_r.bypass_r;
    endsequence

    chk_lock_needs_loop: assert property (lock_indicator_o |->
        $past(st_r.cdr_s2.loop_locked) && $past(st_r.cdr_s2.data_present))
        else $error("lock high without loop lock and data");
    chk_bypass_kills_lock: assert property (s_bypass_pin |=> !lock_indicator_o)
        else $error("lock high during forced bypass");
    chk_silence_mutes: assert property (s_silenced |->
        primary_serial_output_o == DIFF_MUTE && second_serial_output_o == DIFF_MUTE)
        else $error("outputs not muted while silenced");
    chk_std_low_unlocked: assert property (!st_r.lock_r |=> !standard_rate_flag_o)
        else $error("standard flag high while unlocked");
    chk_std_follows: assert property ($rose(lock_indicator_o)
        && st_r.cdr_s2.rate == vrc_pkg::DET_SD && $stable(st_r.cdr_s2.rate)
        |-> ##[1:STD_LAT] standard_rate_flag_o)
        else $error("standard flag late after lock");
    chk_lock_drop: assert property (!st_r.cdr_s2.loop_locked |=> ##[0:2]
        !lock_indicator_o)
        else $error("lock held after loop loss");
    chk_unlock_bypass: assert property (!lock_indicator_o |=> st_r.bypass_r)
        else $error("unlocked without bypass");
    chk_clk_mode_mute: assert property (st_r.pin_s2.clk_sel && st_r.bypass_r
        |=> second_serial_output_o == DIFF_MUTE)
        else $error("second output live in bypassed clock mode");
    chk_refused_rate: assert property (st_r.cdr_s2.rate == vrc_pkg::DET_UNSUP
        |=> !lock_indicator_o ##1 st_r.bypass_r)
        else $error("lock on refused rate");
    chk_bus_ack: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("ack not a single cycle pulse");

    // Bypassed data leaves unretimed, as a true/complement pair
    chk_bypass_raw: assert property (s_passing_raw |=>
        primary_serial_output_o.p == $past(st_r.ser_s2.raw)
        && primary_serial_output_o.n != primary_serial_output_o.p)
        else $error("bypassed output not raw data");

    // Locked and live: the primary pair carries retimed bits
    chk_retimed_data: assert property (s_retiming |=>
        primary_serial_output_o.p == $past(st_r.ser_s2.retimed))
        else $error("locked output not retimed data");

    // Clock mode while retiming: second pair follows the recovered clock
    chk_clock_mode: assert property (s_retiming ##0 st_r.pin_s2.clk_sel |=>
        second_serial_output_o.p == $past(st_r.ser_s2.rec_clk))
        else $error("second output not the recovered clock");

    // Data mode: second pair repeats the primary pair, muted or not
    chk_data_mode: assert property (!st_r.pin_s2.clk_sel |=>
        second_serial_output_o == primary_serial_output_o)
        else $error("second output differs from primary in data mode");

    // The flag may only report a stream that was seen at 270 Mbps
    chk_std_only_sd: assert property (standard_rate_flag_o |->
        $past(st_r.cdr_s2.rate) == vrc_pkg::DET_SD)
        else $error("standard flag high for another rate");

    // Fixed rate modes refuse a foreign stream
    chk_fixed_sd: assert property (st_r.pin_s2.rate_sel == vrc_pkg::RATE_SD
        && st_r.cdr_s2.rate != vrc_pkg::DET_SD |=> !lock_indicator_o)
        else $error("lock in standard mode on a foreign rate");
    chk_fixed_hd: assert property (st_r.pin_s2.rate_sel == vrc_pkg::RATE_HD
        && st_r.cdr_s2.rate != vrc_pkg::DET_HD |=> !lock_indicator_o)
        else $error("lock in high rate mode on a foreign rate");

    // Unbroken qualification reaches lock inside the settle window; a long
    // settle value must still keep this far under the acquisition limit
    chk_lock_in_time: assert property ($rose(qualified) |->
        ##[1:ACQ_LAT] (lock_indicator_o || !qualified))
        else $error("lock not reached after a qualified start");

endmodule
`default_nettype wire

/* vrc_pkg.sv */
// Package with constants and carrier types of the video reclocker control block
`default_nettype none
package vrc_pkg;

    // ------------------------------------------------------------------
    // Register map (word aligned byte addresses)
    // ------------------------------------------------------------------
    localparam logic [3:0] CTRL_OFS   = 4'h0;   // Software overrides, read/write
    localparam logic [3:0] STATUS_OFS = 4'h4;   // Live block state, read only

    // Control register fields
    localparam int CTRL_MUTE_BIT   = 0;         // Software mute
    localparam int CTRL_BYPASS_BIT = 1;         // Software forced bypass
    localparam logic [1:0] CTRL_RST = 2'h0;     // Reset value of control bits

    // Status register fields
    localparam int ST_LOCK_BIT   = 0;           // Lock indicator
    localparam int ST_STD_BIT    = 1;           // Standard rate flag
    localparam int ST_BYPASS_BIT = 2;           // Retiming bypassed
    localparam int ST_MUTE_BIT   = 3;           // Outputs muted
    localparam int ST_CLKSEL_BIT = 4;           // Second output in clock mode
    localparam int ST_VALID_BIT  = 5;           // Second output content valid
    localparam int ST_MODE_LSB   = 8;           // Synchronised rate select code

    // ------------------------------------------------------------------
    // Rate select codes and detected rate classes
    // ------------------------------------------------------------------
    localparam logic [1:0] RATE_AUTO = 2'h0;    // Automatic detection
    localparam logic [1:0] RATE_SD   = 2'h1;    // Fixed standard rate
    localparam logic [1:0] RATE_HD   = 2'h2;    // Fixed high rate

    typedef enum logic [1:0] {
        DET_NONE  = 2'b00,                      // No rate recognised
        DET_SD    = 2'b01,                      // 270 Mbps
        DET_HD    = 2'b10,                      // 1483..2970 Mbps
        DET_UNSUP = 2'b11                       // Refused rates, never locked
    } vrc_det_t;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;          // Block clock period
    localparam int STD_VALID_NS  = 37;          // Flag valid after lock edge
    localparam int STD_VALID_CYC = (STD_VALID_NS / CLK_PERIOD_NS < 1) ? 1
                                   : STD_VALID_NS / CLK_PERIOD_NS;
    localparam int ACQ_MAX_MS    = 15;          // Longest acquisition time
    localparam int ACQ_MAX_CYC   = ACQ_MAX_MS * 1000000 / CLK_PERIOD_NS;
    localparam int DROP_MAX_MS   = 1;           // Longest lock drop time
    localparam int DROP_MAX_CYC  = DROP_MAX_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SYNC_CYC      = 2;           // Synchroniser depth

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic     loop_locked;                  // Clock recovery loop locked
        logic     data_present;                 // Input carrier detected
        vrc_det_t rate;                         // Detected rate class
    } vrc_cdr_t;

    typedef struct packed {
        logic retimed;                          // Retimed data bit
        logic raw;                              // Input data, not retimed
        logic rec_clk;                          // Recovered data-rate clock
    } vrc_serial_t;

    typedef struct packed {
        logic p;                                // True half
        logic n;                                // Complement half
    } vrc_diff_t;

    typedef struct packed {
        logic       clk_sel;                    // Second output clock select
        logic [1:0] rate_sel;                   // Rate select pins
        logic       bypass;                     // Bypass input
        logic       silence_n;                  // Output silence, active low
    } vrc_pins_t;

    // Whole state of the control module
    typedef struct packed {
        vrc_pins_t   pin_s1;                    // First synchroniser stage
        vrc_pins_t   pin_s2;                    // Second synchroniser stage
        vrc_cdr_t    cdr_s1;
        vrc_cdr_t    cdr_s2;
        vrc_serial_t ser_s1;
        vrc_serial_t ser_s2;
        logic [1:0]  ctrl_r;                    // Software control bits
        logic [20:0] settle_r;                  // Qualified-lock counter
        logic        lock_r;
        logic        std_r;
        logic        bypass_r;
        logic        mute_r;
        logic        valid2_r;
        vrc_diff_t   out1_r;
        vrc_diff_t   out2_r;
        logic        ack_r;
        logic [31:0] dat_r;
    } vrc_state_t;

endpackage
`default_nettype wire

/* vrc_far_model.sv */
// Upstream equalizer and recovery loop model feeding the reclocker control block
`default_nettype none
module vrc_far_model #(
    parameter int ACQ_CYC = 6                   // Loop acquisition time in cycles
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 data_on_i,  // Carrier present on the cable
    input  wire vrc_pkg::vrc_det_t    rate_i,     // Rate class of the stream
    input  wire vrc_pkg::vrc_serial_t bits_i,     // Bit levels to present
    output vrc_pkg::vrc_cdr_t         cdr_o,      // Loop status towards the block
    output vrc_pkg::vrc_serial_t      serial_o    // Serial bits towards the block
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Acquisition
    // ------------------------------------------------------------------
    logic [7:0] acq_r;                            // Cycles since carrier arrived

    // Loop claims lock even at refused rates: refusing is the block's job
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !data_on_i)
        begin
            acq_r <= 8'h00;
            cdr_o <= '0;
        end
        else
        begin
            if (acq_r < 8'(ACQ_CYC))
                acq_r <= acq_r + 8'h01;
            cdr_o <= '{loop_locked: acq_r >= 8'(ACQ_CYC), data_present: 1'b1, rate: rate_i};
        end
    end

    // ------------------------------------------------------------------
    // Serial bits
    // ------------------------------------------------------------------
    // Without carrier the bits are noise, so they change every cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            serial_o <= 3'h5;
        else
            serial_o <= data_on_i ? bits_i : ~serial_o;
    end
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking testbench of the reclocker control block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                clk_i, rst_i, cyc, stb, we, ack, lock, std, valid2, data_on;
    logic [3:0]          adr, sel;
    logic [31:0]         dat, rdat, q;
    vrc_pkg::vrc_pins_t  pins;                  // Control pins
    vrc_pkg::vrc_det_t   rate;                  // Rate of the far stream
    vrc_pkg::vrc_serial_t bits, ser;            // Far bit levels
    vrc_pkg::vrc_cdr_t   cdr;
    vrc_pkg::vrc_diff_t  out1, out2;
    int                  miscompares, samples_checked, i;
    logic [5:0]          tab [7];               // {rate_sel, det, lock, std}

    vrc_far_model u_far (.clk_i(clk_i), .rst_i(rst_i), .data_on_i(data_on), .rate_i(rate),
        .bits_i(bits), .cdr_o(cdr), .serial_o(ser));
    vrc_ctrl #(.LOCK_SETTLE_CYC(2)) DUT (.clk_i(clk_i), .rst_i(rst_i), .pins_i(pins),
        .cdr_i(cdr), .serial_i(ser), .lock_indicator_o(lock), .standard_rate_flag_o(std),
        .second_output_valid_o(valid2), .primary_serial_output_o(out1),
        .second_serial_output_o(out2), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack));

    // ------------------------------------------------------------------
    // Clock and helpers
    // ------------------------------------------------------------------
    // Stands in for the system's timing reference
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One classic cycle; hangs are cut short after 50 cycles
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50)
        begin
            miscompares++;
            print_verdict();
        end
    endtask

    // Carrier off, then a new stream under a new rate selection
    task automatic restart(input logic [1:0] s, input vrc_pkg::vrc_det_t d);
        data_on <= 1'b0;
        tick(20);
        pins.rate_sel <= s;
        rate <= d;
        data_on <= 1'b1;
        tick(60);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        rst_i = 1'b1;
        pins = '{1'b0, 2'h0, 1'b0, 1'b1};
        {cyc, stb, we, adr, sel, dat, data_on} = '0;
        rate = vrc_pkg::DET_NONE;
        bits = 3'h0;
        tab = '{6'h07, 6'h0A, 6'h17, 6'h18, 6'h2A, 6'h24, 6'h3A};
        tick(16);
        rst_i <= 1'b0;
        tick(1);
        chk("lock", 32'h0, lock);
        chk("out1", 32'h1, out1);
        chk("out2", 32'h1, out2);
        wb(1'b0, vrc_pkg::CTRL_OFS, 32'h0);
        chk("ctrl", 32'(vrc_pkg::CTRL_RST), q);
        // Refused rate with clock mode: raw data, second output muted
        bits <= 3'h3;
        pins.clk_sel <= 1'b1;
        restart(2'h0, vrc_pkg::DET_UNSUP);
        chk("lock", 32'h0, lock);
        chk("out1", 32'h2, out1);
        chk("out2", 32'h1, out2);
        chk("valid2", 32'h0, valid2);
        pins.clk_sel <= 1'b0;
        tick(8);
        chk("out2", 32'h2, out2);
        chk("valid2", 32'h1, valid2);
        // Each rate selection against SD and HD streams, code 11 against HD only; code 11 acts as automatic
        for (i = 0; i < 7; i++)
        begin
            restart(tab[i][5:4], vrc_pkg::vrc_det_t'(tab[i][3:2]));
            chk("lock", 32'(tab[i][1]), lock);
            chk("std", 32'(tab[i][0]), std);
        end
        // Locked in automatic mode: retimed bits and recovered clock
        bits <= 3'h4;
        restart(2'h0, vrc_pkg::DET_SD);
        chk("out1", 32'h2, out1);
        chk("out2", 32'h2, out2);
        pins.clk_sel <= 1'b1;
        bits <= 3'h1;
        tick(8);
        chk("out2", 32'h2, out2);
        chk("out1", 32'h1, out1);
        wb(1'b0, vrc_pkg::STATUS_OFS, 32'h0);
        chk("status", 32'h33, q);
        // Forced bypass by pin, then silencing on top of it
        bits <= 3'h2;
        pins.bypass <= 1'b1;
        tick(8);
        chk("lock", 32'h0, lock);
        chk("std", 32'h0, std);
        chk("out1", 32'h2, out1);
        chk("out2", 32'h1, out2);
        pins.silence_n <= 1'b0;
        tick(8);
        chk("out1", 32'h1, out1);
        chk("out2", 32'h1, out2);
        pins <= '{1'b0, 2'h0, 1'b0, 1'b1};
        bits <= 3'h7;
        tick(60);
        chk("lock", 32'h1, lock);
        // Software bypass and mute
        wb(1'b1, vrc_pkg::CTRL_OFS, 32'h2);
        tick(8);
        chk("lock", 32'h0, lock);
        wb(1'b1, vrc_pkg::CTRL_OFS, 32'h1);
        wb(1'b1, vrc_pkg::STATUS_OFS, 32'hFF);
        wb(1'b0, vrc_pkg::CTRL_OFS, 32'h0);
        chk("ctrl", 32'h1, q);
        tick(8);
        chk("out1", 32'h1, out1);
        wb(1'b0, 4'hC, 32'h0);
        chk("unmapped", 32'h0, q);
        wb(1'b1, vrc_pkg::CTRL_OFS, 32'h0);
        tick(60);
        // Carrier loss drops lock within a bounded time
        data_on <= 1'b0;
        i = 0;
        do
        begin
            tick(1);
            i++;
        end
        while (lock !== 1'b0 && i < 60);
        chk("lock", 32'h0, lock);
        tick(2);
        chk("std", 32'h0, std);
        print_verdict();
    end
endmodule
`default_nettype wire
